// *** ring_pkg.sv ***
// Constants, register map and link carriers for the ring master
//
// Summary of operation
// - Procedure start drives value 3: set flag bit 0, enable flag bit 1.
// - Procedure handshake: two bits out, six status bits back, same for every procedure.
// - On status 3 or error bit, master cancels by driving value 0.
// - Initialization steps through phases 0 to 4 strictly in order.
// - Phase 1 addresses each slave alone and waits for its acknowledge.
// - Optional hold after phase 2; continue request resumes phase advance.
// - Cyclic data sent every cycle, only after phase 4 completes.
// - Each data telegram carries one service channel word, zero when no transfer is busy.
// - Service transfers allowed only after phase 2, 3 or 4 completes.
// - Master starts every service transfer, one at a time to completion.
// - Up to 16 queued ladder requests, served in arrival order.
// - Ladder queue fully served before any diagnostic request.
// - Close-loop sets top three control bits; open-loop clears them.
// - Error code 5 when axis rate differs from ring rate.
// - Sync telegram, then slave replies, then data telegram after last reply.
package ring_pkg;
	localparam int CLK_NS = 20;
	localparam int CYCLE_NS = 2000;
	localparam int CYCLE_CLKS = CYCLE_NS / CLK_NS;
	localparam logic [6:0] TMR_LOAD = 7'(CYCLE_CLKS - 1);
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_LREQ = 8'h08;
	localparam logic [7:0] A_DREQ = 8'h0c;
	localparam logic [7:0] A_SCRX = 8'h10;
	localparam logic [7:0] A_CYC = 8'h14;
	localparam logic [7:0] A_ARATE = 8'h18;
	localparam logic [7:0] A_RRATE = 8'h1c;
	localparam logic [7:0] A_NSLV = 8'h20;
	localparam int C_RUN = 0;
	localparam int C_HOLD = 1;
	localparam int C_CONT = 2;
	localparam int C_CLOSE = 3;
	localparam int C_OPEN = 4;
	localparam int C_PCF_GO = 5;
	localparam int C_PCF_STOP = 6;
	localparam int ST_QERR = 19;
	localparam logic [31:0] CTRL_KEEP = 32'h0000_0003;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [7:0] NSLV_RST = 8'h01;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// ----------------------------------------------------------------
	// Protocol values
	// ----------------------------------------------------------------
	localparam logic [2:0] CP_P1 = 3'h1;
	localparam logic [2:0] CP_P2 = 3'h2;
	localparam logic [2:0] CP_P2DONE = 3'h3;
	localparam logic [2:0] PH_LAST = 3'h4;
	localparam logic [2:0] CP_ALL = 3'h5;
	localparam logic [1:0] PCF_START = 2'h3;
	localparam logic [1:0] PCF_CANCEL = 2'h0;
	localparam logic [3:0] PCF_OK = 4'h3;
	localparam int PCF_ERR_BIT = 3;
	localparam int PCF_CHG_BIT = 5;
	localparam int LOOP_BITS = 3;
	localparam logic [3:0] ERR_RATE = 4'h5;
	localparam int Q_DEPTH = 16;
	localparam logic [4:0] Q_FULL = 5'h10;
	typedef enum logic [3:0] {
		SQ_IDLE = 4'b0001,
		SQ_SYNC = 4'b0010,
		SQ_WAIT = 4'b0100,
		SQ_DATA = 4'b1000
	} seq_e;
	typedef struct packed {
		logic reply_last;
		logic sc_ack;
		logic phase_ack;
		logic [5:0] pcf_stat;
		logic [15:0] sc_word;
	} link_in_s;
	typedef struct packed {
		logic sync_tx;
		logic data_tx;
		logic cyc_en;
		logic [1:0] pcf;
		logic [2:0] phase;
		logic [7:0] slave;
		logic [15:0] sc_word;
		logic [15:0] ctrl_word;
		logic [31:0] cyc_word;
	} link_out_s;
endpackage : ring_pkg

// *** ring_master.sv ***
`timescale 1ns/1ps
// Ring master: register slave, phase stepping, telegram sequencing, service channel
module ring_master
	import ring_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire link_in_s LINK_IN,
	output link_out_s LINK_OUT
);
	// ----------------------------------------------------------------
	// Link input synchronisers
	// ----------------------------------------------------------------
	link_in_s sync1_ff, sync2_ff, prev_ff;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			prev_ff <= '0;
		end else begin
			sync1_ff <= LINK_IN;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end
	wire last_evt = sync2_ff.reply_last & ~prev_ff.reply_last;
	wire ack_evt = sync2_ff.sc_ack & ~prev_ff.sc_ack;
	wire phase_evt = sync2_ff.phase_ack & ~prev_ff.phase_ack;
	// Procedure status counts as new on a change flag edge or a changed value
	wire pcf_evt = (sync2_ff.pcf_stat != prev_ff.pcf_stat)
		| (sync2_ff.pcf_stat[PCF_CHG_BIT] ^ prev_ff.pcf_stat[PCF_CHG_BIT]);
	// ----------------------------------------------------------------
	// Register bus slave
	// ----------------------------------------------------------------
	logic aw_ff, w_ff, awrdy_ff, wrdy_ff, bvalid_ff, arrdy_ff, rvalid_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff, rd_data;
	logic [3:0] wstrb_ff;
	wire [31:0] wmask;
	wire wr_do = aw_ff & w_ff & ~bvalid_ff;
	wire ar_take = ARVALID & arrdy_ff;
	wire rd_ok = ARADDR inside {A_CTRL, A_STAT, A_LREQ, A_DREQ, A_SCRX, A_CYC, A_ARATE,
		A_RRATE, A_NSLV};
	wire nxt_aw = (aw_ff | (AWVALID & awrdy_ff)) & ~wr_do;
	wire nxt_w = (w_ff | (WVALID & wrdy_ff)) & ~wr_do;
	wire nxt_rv = (rvalid_ff & ~RREADY) | ar_take;
	for (genvar b = 0; b < 4; b++) begin : g_strb
		assign wmask[8*b +: 8] = {8{wstrb_ff[b]}};
	end
	wire [31:0] wpulse = wdata_ff & wmask;
	function automatic logic [31:0] merge(input logic [31:0] old);
		return (old & ~wmask) | wpulse;
	endfunction : merge
	wire we_ctrl = wr_do & (awaddr_ff == A_CTRL);
	wire we_stat = wr_do & (awaddr_ff == A_STAT);
	wire we_lreq = wr_do & (awaddr_ff == A_LREQ);
	wire we_dreq = wr_do & (awaddr_ff == A_DREQ);
	wire we_cyc = wr_do & (awaddr_ff == A_CYC);
	wire we_arate = wr_do & (awaddr_ff == A_ARATE);
	wire we_rrate = wr_do & (awaddr_ff == A_RRATE);
	wire we_nslv = wr_do & (awaddr_ff == A_NSLV);
	wire wr_hit = we_ctrl | we_stat | we_lreq | we_dreq | we_cyc | we_arate | we_rrate | we_nslv;
	wire go_cont = we_ctrl & wpulse[C_CONT];
	wire go_close = we_ctrl & wpulse[C_CLOSE];
	wire go_open = we_ctrl & wpulse[C_OPEN];
	wire go_pcf = we_ctrl & wpulse[C_PCF_GO];
	wire go_stop = we_ctrl & wpulse[C_PCF_STOP];
	wire clr_qerr = we_stat & wpulse[ST_QERR];
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awrdy_ff <= 1'b0;
			wrdy_ff <= 1'b0;
			arrdy_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			bresp_ff <= RESP_OK;
			rresp_ff <= RESP_OK;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			rdata_ff <= '0;
		end else begin
			aw_ff <= nxt_aw;
			w_ff <= nxt_w;
			awrdy_ff <= ~nxt_aw;
			wrdy_ff <= ~nxt_w;
			arrdy_ff <= ~nxt_rv;
			rvalid_ff <= nxt_rv;
			if (AWVALID & awrdy_ff) awaddr_ff <= AWADDR;
			if (WVALID & wrdy_ff) begin
				wdata_ff <= WDATA;
				wstrb_ff <= WSTRB;
			end
			if (wr_do) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wr_hit ? RESP_OK : RESP_ERR;
			end else if (BREADY) begin
				bvalid_ff <= 1'b0;
			end
			if (ar_take) begin
				rdata_ff <= rd_data;
				rresp_ff <= rd_ok ? RESP_OK : RESP_ERR;
			end
		end
	end
	// ----------------------------------------------------------------
	// Control state
	// ----------------------------------------------------------------
	logic [31:0] ctrl_ff, cyc_ff, arate_ff, rrate_ff;
	logic [7:0] nslv_ff, slv_ff;
	logic [2:0] cp_ff;
	logic held_ff, loop_ff, pcf_done_ff, pcf_err_ff, qerr_ff, busy_ff, dpend_ff;
	logic [1:0] pcf_ff;
	logic [3:0] err_code_ff;
	logic [15:0] scrx_ff, sc_cur_ff, dreq_ff;
	logic [15:0] q_mem [Q_DEPTH];
	logic [3:0] wp_ff, rp_ff;
	logic [4:0] cnt_ff;
	wire phase_run = ctrl_ff[C_RUN] & ~held_ff & (cp_ff != CP_ALL);
	wire ph1_more = (cp_ff == CP_P1) & (slv_ff != nslv_ff - 8'h01);
	wire [2:0] cur_phase = (cp_ff == CP_ALL) ? PH_LAST : cp_ff;
	wire sc_ok = cp_ff >= CP_P2DONE;
	wire q_empty = cnt_ff == 5'h00;
	wire q_full = cnt_ff == Q_FULL;
	wire sc_start = sc_ok & ~busy_ff & (~q_empty | dpend_ff);
	wire pop = sc_start & ~q_empty;
	wire take_diag = sc_start & q_empty;
	wire push = we_lreq & ~q_full;
	wire pcf_fin = (sync2_ff.pcf_stat[3:0] == PCF_OK) | sync2_ff.pcf_stat[PCF_ERR_BIT];
	wire auto_stop = (pcf_ff == PCF_START) & pcf_evt & pcf_fin;
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl_ff <= CTRL_RST;
			cyc_ff <= '0;
			arate_ff <= '0;
			rrate_ff <= '0;
			nslv_ff <= NSLV_RST;
		end else begin
			if (we_ctrl) ctrl_ff <= merge(ctrl_ff) & CTRL_KEEP;
			if (we_cyc) cyc_ff <= merge(cyc_ff);
			if (we_arate) arate_ff <= merge(arate_ff);
			if (we_rrate) rrate_ff <= merge(rrate_ff);
			if (we_nslv) nslv_ff <= 8'(merge({24'h0, nslv_ff}));
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cp_ff <= '0;
			slv_ff <= '0;
			held_ff <= 1'b0;
		end else if (!ctrl_ff[C_RUN]) begin
			cp_ff <= '0;
			slv_ff <= '0;
			held_ff <= 1'b0;
		end else if (phase_run & phase_evt) begin
			if (ph1_more) slv_ff <= slv_ff + 8'h01;
			else cp_ff <= cp_ff + 3'h1;
			if (!ph1_more && cp_ff == CP_P2 && ctrl_ff[C_HOLD]) held_ff <= 1'b1;
		end else if (go_cont) begin
			held_ff <= 1'b0;
		end
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pcf_ff <= PCF_CANCEL;
			pcf_done_ff <= 1'b0;
			pcf_err_ff <= 1'b0;
			loop_ff <= 1'b0;
			err_code_ff <= '0;
		end else begin
			if (go_pcf) pcf_ff <= PCF_START;
			else if (go_stop | auto_stop) pcf_ff <= PCF_CANCEL;
			pcf_done_ff <= (pcf_done_ff & ~go_pcf) | (auto_stop & ~sync2_ff.pcf_stat[PCF_ERR_BIT]);
			pcf_err_ff <= (pcf_err_ff & ~go_pcf) | (auto_stop & sync2_ff.pcf_stat[PCF_ERR_BIT]);
			if (go_close) loop_ff <= 1'b1;
			else if (go_open) loop_ff <= 1'b0;
			err_code_ff <= (arate_ff != rrate_ff) ? ERR_RATE : 4'h0;
		end
	end
	// ----------------------------------------------------------------
	// Service channel queue and transfer
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (push) q_mem[wp_ff] <= wdata_ff[15:0];
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
			qerr_ff <= 1'b0;
			busy_ff <= 1'b0;
			dpend_ff <= 1'b0;
			dreq_ff <= '0;
			sc_cur_ff <= '0;
			scrx_ff <= '0;
		end else begin
			if (push) wp_ff <= wp_ff + 4'h1;
			if (pop) rp_ff <= rp_ff + 4'h1;
			cnt_ff <= cnt_ff + {4'h0, push} - {4'h0, pop};
			// Refusal wins over a clear in the same cycle
			qerr_ff <= (qerr_ff & ~clr_qerr) | (we_lreq & q_full);
			dpend_ff <= (dpend_ff & ~take_diag) | we_dreq;
			if (we_dreq) dreq_ff <= wdata_ff[15:0];
			if (sc_start) begin
				busy_ff <= 1'b1;
				sc_cur_ff <= q_empty ? dreq_ff : q_mem[rp_ff];
			end else if (busy_ff & ack_evt) begin
				busy_ff <= 1'b0;
				scrx_ff <= sync2_ff.sc_word;
			end
		end
	end
	// ----------------------------------------------------------------
	// Telegram sequencer
	// ----------------------------------------------------------------
	seq_e seq_ff, nxt_seq;
	logic [6:0] tmr_ff;
	link_out_s out_ff;
	wire tmr_zero = tmr_ff == 7'h00;
	always_comb begin
		nxt_seq = seq_ff;
		unique case (seq_ff)
			SQ_IDLE: if (tmr_zero) nxt_seq = SQ_SYNC;
			SQ_SYNC: nxt_seq = SQ_WAIT;
			SQ_WAIT: if (last_evt) nxt_seq = SQ_DATA; else if (tmr_zero) nxt_seq = SQ_IDLE;
			SQ_DATA: nxt_seq = SQ_IDLE;
		endcase
	end
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			seq_ff <= SQ_IDLE;
			tmr_ff <= TMR_LOAD;
			out_ff <= '0;
		end else begin
			seq_ff <= nxt_seq;
			tmr_ff <= tmr_zero ? TMR_LOAD : tmr_ff - 7'h01;
			out_ff.sync_tx <= seq_ff == SQ_SYNC;
			out_ff.data_tx <= seq_ff == SQ_DATA;
			out_ff.phase <= cur_phase;
			out_ff.slave <= slv_ff;
			if (seq_ff == SQ_DATA) begin
				out_ff.sc_word <= busy_ff ? sc_cur_ff : 16'h0000;
				out_ff.pcf <= pcf_ff;
				out_ff.cyc_en <= cp_ff == CP_ALL;
				out_ff.cyc_word <= (cp_ff == CP_ALL) ? cyc_ff : 32'h0;
				out_ff.ctrl_word <= {{LOOP_BITS{loop_ff}}, 13'h0000};
			end
		end
	end
	// ----------------------------------------------------------------
	// Read decode and outputs
	// ----------------------------------------------------------------
	wire [31:0] stat_w = {4'h0, err_code_ff, 3'h0, busy_ff, qerr_ff, cnt_ff, pcf_err_ff,
		pcf_done_ff, sync2_ff.pcf_stat, loop_ff, cp_ff == CP_ALL, held_ff, cur_phase};
	assign rd_data = (ARADDR == A_CTRL) ? ctrl_ff :
		(ARADDR == A_STAT) ? stat_w :
		(ARADDR == A_SCRX) ? {16'h0, scrx_ff} :
		(ARADDR == A_CYC) ? cyc_ff :
		(ARADDR == A_ARATE) ? arate_ff :
		(ARADDR == A_RRATE) ? rrate_ff :
		(ARADDR == A_NSLV) ? {24'h0, nslv_ff} : 32'h0;
	assign AWREADY = awrdy_ff;
	assign WREADY = wrdy_ff;
	assign BVALID = bvalid_ff;
	assign BRESP = bresp_ff;
	assign ARREADY = arrdy_ff;
	assign RVALID = rvalid_ff;
	assign RDATA = rdata_ff;
	assign RRESP = rresp_ff;
	assign LINK_OUT = out_ff;
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	property p_pcf_start; go_pcf |=> pcf_ff == PCF_START; endproperty
	a_pcf_start: assert property (p_pcf_start) else $error("procedure start not 3");
	property p_pcf_cancel; auto_stop & ~go_pcf |=> pcf_ff == PCF_CANCEL; endproperty
	a_pcf_cancel: assert property (p_pcf_cancel) else $error("procedure not cancelled");
	property p_phase_step; ctrl_ff[C_RUN] & $past(ctrl_ff[C_RUN]) |->
		cp_ff == $past(cp_ff) || cp_ff == $past(cp_ff) + 3'h1; endproperty
	a_phase_step: assert property (p_phase_step) else $error("phase skipped");
	property p_ph1; phase_run & phase_evt & ph1_more |=>
		cp_ff == CP_P1 && slv_ff == $past(slv_ff) + 8'h01; endproperty
	a_ph1: assert property (p_ph1) else $error("phase 1 slave step wrong");
	property p_hold; held_ff & ctrl_ff[C_RUN] |=> $stable(cp_ff); endproperty
	a_hold: assert property (p_hold) else $error("phase moved while held");
	property p_cyc; out_ff.cyc_en |-> cp_ff == CP_ALL; endproperty
	a_cyc: assert property (p_cyc) else $error("cyclic data before phase 4");
	property p_sc_one; busy_ff & ~ack_evt |=> busy_ff && $stable(sc_cur_ff) && sc_ok; endproperty
	a_sc_one: assert property (p_sc_one) else $error("service transfer overlapped");
	property p_fifo; push & ~pop |=> cnt_ff == $past(cnt_ff) + 5'h01; endproperty
	a_fifo: assert property (p_fifo) else $error("queue count wrong");
	property p_prio; sc_start & dpend_ff & ~q_empty |=> dpend_ff; endproperty
	a_prio: assert property (p_prio) else $error("diagnostic ahead of ladder");
	property p_loop; out_ff.data_tx |-> out_ff.ctrl_word[15:13] == {3{$past(loop_ff)}}; endproperty
	a_loop: assert property (p_loop) else $error("control word loop bits wrong");
	property p_rate; arate_ff != rrate_ff |=> err_code_ff == ERR_RATE; endproperty
	a_rate: assert property (p_rate) else $error("rate error code missing");
	sequence s_last_seen; seq_ff == SQ_WAIT && last_evt; endsequence
	sequence s_data_out; seq_ff == SQ_DATA ##1 out_ff.data_tx; endsequence
	property p_order; s_last_seen |=> s_data_out; endproperty
	a_order: assert property (p_order) else $error("data telegram not after last reply");
	property p_full; we_lreq & q_full & ~pop |=> qerr_ff && cnt_ff == Q_FULL; endproperty
	a_full: assert property (p_full) else $error("full queue not refused");
endmodule : ring_master

// *** ring_slave_model.sv ***
`timescale 1ns/1ps
// Behavioural drive slaves answering the ring master's telegrams
module ring_slave_model
	import ring_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic fail,
	input wire link_out_s lo,
	output wire link_in_s li
);
	logic [7:0] t_ff;
	logic [2:0] pc_ff;
	logic [5:0] st_ff;
	logic [15:0] ret_ff;
	logic ph_ff;
	logic sc_ff;
	// ----------------------------------------------------------------
	// Reply timing and procedure status
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			t_ff <= 8'hff;
			pc_ff <= 3'h0;
			st_ff <= 6'h00;
			ret_ff <= 16'h0000;
			ph_ff <= 1'b0;
			sc_ff <= 1'b0;
		end else begin
			if (lo.sync_tx) begin
				t_ff <= 8'h00;
				ph_ff <= 1'b0;
				sc_ff <= 1'b0;
			end else if (t_ff != 8'hff) begin
				t_ff <= t_ff + 8'h01;
			end
			if (lo.data_tx) begin
				ph_ff <= !lo.cyc_en;
				sc_ff <= lo.sc_word != 16'h0000;
				ret_ff <= ~lo.sc_word;
				if (lo.pcf == PCF_START) begin
					if (pc_ff != 3'h7) pc_ff <= pc_ff + 3'h1;
					if (pc_ff == 3'h0) st_ff <= {~st_ff[5], 5'h07};
					if (pc_ff == 3'h3) st_ff <= {~st_ff[5], 1'b0, fail ? 4'hf : 4'h3};
				end else begin
					pc_ff <= 3'h0;
					st_ff <= 6'h00;
				end
			end
		end
	end
	assign li.reply_last = t_ff >= 8'h0a && t_ff < 8'h0e;
	assign li.phase_ack = ph_ff && t_ff >= 8'h18 && t_ff < 8'h1c;
	assign li.sc_ack = sc_ff && t_ff >= 8'h18 && t_ff < 8'h1c;
	// Released service line shows the inverse, so a stale word is never mistaken
	assign li.sc_word = li.sc_ack ? ret_ff : ~ret_ff;
	assign li.pcf_stat = st_ff;
endmodule : ring_slave_model

// *** ring_master_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the ring master
module ring_master_tb
	import ring_pkg::*;
;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic [7:0] AWADDR = 8'h00;
	logic AWVALID = 1'b0;
	logic [31:0] WDATA = 32'h0;
	logic [3:0] WSTRB = 4'h0;
	logic WVALID = 1'b0;
	logic BREADY = 1'b0;
	logic [7:0] ARADDR = 8'h00;
	logic ARVALID = 1'b0;
	logic RREADY = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0] BRESP, RRESP, r;
	logic [31:0] RDATA, d;
	link_in_s LINK_IN;
	link_out_s LINK_OUT;
	logic fail = 1'b0;
	int failures = 0;
	int tests_run = 0;
	int i;
	logic [15:0] seen[$];
	logic [15:0] last = 16'h0000;
	logic [2:0] lph = 3'h0;
	logic [7:0] maxs = 8'h00;
	logic rep = 1'b0;
	ring_master u_ring_master (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.LINK_IN(LINK_IN), .LINK_OUT(LINK_OUT));
	ring_slave_model u_ring_slave_model (.clk(CLK), .rst(RST), .fail(fail), .lo(LINK_OUT),
		.li(LINK_IN));
	initial begin
		forever #10 CLK = ~CLK;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task end_sim;
		$display("tests_run=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	task tmo;
		failures++;
		$display("CHECK FAILED %0t timeout", $time);
		end_sim();
	endtask : tmo
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
		int n;
		logic ta;
		logic tw;
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= v;
		WSTRB <= 4'hf;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(negedge CLK);
			if (BVALID === 1'b1) begin
				s = BRESP;
				@(posedge CLK);
				BREADY <= 1'b0;
				return;
			end
			ta = AWVALID && AWREADY === 1'b1;
			tw = WVALID && WREADY === 1'b1;
			@(posedge CLK);
			if (ta) AWVALID <= 1'b0;
			if (tw) WVALID <= 1'b0;
		end
		tmo();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] s);
		int n;
		logic ta;
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(negedge CLK);
			if (RVALID === 1'b1) begin
				q = RDATA;
				s = RRESP;
				@(posedge CLK);
				RREADY <= 1'b0;
				return;
			end
			ta = ARVALID && ARREADY === 1'b1;
			@(posedge CLK);
			if (ta) ARVALID <= 1'b0;
		end
		tmo();
	endtask : rd
	task automatic wait_eq(input int sel, input logic [15:0] v);
		int n;
		logic [15:0] x;
		for (n = 0; n < 20000; n++) begin
			@(negedge CLK);
			case (sel)
				0: x = 16'(LINK_OUT.phase);
				1: x = 16'(LINK_OUT.pcf);
				2: x = LINK_OUT.ctrl_word;
				3: x = 16'(LINK_OUT.cyc_en);
				4: x = 16'(seen.size());
				default: x = LINK_OUT.cyc_word[15:0];
			endcase
			if (x === v) begin
				tests_run++;
				return;
			end
		end
		tmo();
	endtask : wait_eq
	// ----------------------------------------------------------------
	// Telegram monitor
	// ----------------------------------------------------------------
	always @(negedge CLK) begin
		if (LINK_IN.reply_last) rep <= 1'b1;
		if (LINK_OUT.sync_tx) rep <= 1'b0;
		if (LINK_OUT.phase !== lph) begin
			chk(32'(LINK_OUT.phase), 32'(lph) + 32'h1, "phase step");
			lph <= LINK_OUT.phase;
		end
		if (LINK_OUT.data_tx === 1'b1) begin
			chk(32'(rep), 32'h1, "data before reply");
			chk(32'(LINK_OUT.cyc_en && LINK_OUT.phase != PH_LAST), 32'h0, "cyclic early");
			chk(32'(LINK_OUT.phase < CP_P2DONE && LINK_OUT.sc_word != 16'h0), 32'h0, "sc early");
			if (LINK_OUT.phase == CP_P1 && LINK_OUT.slave > maxs) maxs <= LINK_OUT.slave;
			if (LINK_OUT.sc_word != 16'h0 && LINK_OUT.sc_word != last) begin
				seen.push_back(LINK_OUT.sc_word);
				last <= LINK_OUT.sc_word;
			end
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge CLK);
		RST <= 1'b0;
		repeat (3) @(posedge CLK);
		rd(A_CTRL, d, r);
		chk(d, CTRL_RST, "ctrl reset");
		chk({30'h0, r}, 32'(RESP_OK), "mapped rd");
		rd(A_NSLV, d, r);
		chk(d, 32'(NSLV_RST), "nslv reset");
		rd(8'h40, d, r);
		chk({30'h0, r}, 32'(RESP_ERR), "unmapped rd");
		chk(d, 32'h0, "unmapped data");
		wr(8'h44, 32'h1, r);
		chk({30'h0, r}, 32'(RESP_ERR), "unmapped wr");
		$display("test regs done");
		for (i = 0; i < Q_DEPTH; i++) wr(A_LREQ, 32'h0a00 + 32'(i), r);
		wr(A_DREQ, 32'h0d0d, r);
		wr(A_LREQ, 32'h0bad, r);
		rd(A_STAT, d, r);
		chk(32'(d[19:14]), 32'h30, "queue full");
		wr(A_STAT, 32'h0008_0000, r);
		rd(A_STAT, d, r);
		chk(32'(d[19:14]), 32'h10, "refusal cleared");
		$display("test queue done");
		wr(A_NSLV, 32'h2, r);
		chk({30'h0, r}, 32'(RESP_OK), "mapped wr");
		wr(A_CTRL, 32'h3, r);
		wait_eq(0, 16'(CP_P1));
		for (i = 0; i < 1000 && d[3] !== 1'b1; i++) rd(A_STAT, d, r);
		chk(32'(d[3]), 32'h1, "held");
		repeat (500) @(negedge CLK);
		chk(32'(LINK_OUT.cyc_en), 32'h0, "cyclic in hold");
		chk(32'(maxs), 32'h1, "slaves addressed");
		wr(A_CTRL, 32'h7, r);
		wait_eq(3, 16'h1);
		chk(32'(LINK_OUT.phase), 32'(PH_LAST), "phase 4");
		$display("test phases done");
		wait_eq(4, 16'h11);
		for (i = 0; i < Q_DEPTH; i++) chk(32'(seen[i]), 32'h0a00 + 32'(i), "ladder order");
		chk(32'(seen[16]), 32'h0d0d, "diag last");
		repeat (300) @(posedge CLK);
		rd(A_SCRX, d, r);
		chk(d, 32'hf2f2, "returned word");
		$display("test service done");
		wr(A_CYC, 32'h1234_5678, r);
		wait_eq(5, 16'h5678);
		chk(LINK_OUT.cyc_word, 32'h1234_5678, "cyclic word");
		wr(A_CTRL, 32'h23, r);
		wait_eq(1, 16'(PCF_START));
		wait_eq(1, 16'(PCF_CANCEL));
		rd(A_STAT, d, r);
		chk(32'(d[12]), 32'h1, "pcf ok");
		rd(A_CTRL, d, r);
		chk(d, 32'h3, "pulse bits read 0");
		fail <= 1'b1;
		wr(A_CTRL, 32'h23, r);
		wait_eq(1, 16'(PCF_START));
		wait_eq(1, 16'(PCF_CANCEL));
		rd(A_STAT, d, r);
		chk(32'(d[13]), 32'h1, "pcf error");
		wr(A_CTRL, 32'h23, r);
		wait_eq(1, 16'(PCF_START));
		wr(A_CTRL, 32'h43, r);
		wait_eq(1, 16'(PCF_CANCEL));
		rd(A_STAT, d, r);
		chk(32'(d[13:12]), 32'h0, "pcf user cancel");
		$display("test procedure done");
		wr(A_CTRL, 32'h0b, r);
		wait_eq(2, 16'he000);
		wr(A_CTRL, 32'h13, r);
		wait_eq(2, 16'h0000);
		wr(A_ARATE, 32'h5, r);
		wr(A_RRATE, 32'h6, r);
		rd(A_STAT, d, r);
		chk(32'(d[27:24]), 32'(ERR_RATE), "rate error");
		wr(A_RRATE, 32'h5, r);
		rd(A_STAT, d, r);
		chk(32'(d[27:24]), 32'h0, "rate equal");
		$display("test loop and rate done");
		end_sim();
	end
endmodule : ring_master_tb
